// ### dv/host_board_model.sv
// Host board model: strap jumpers and the transceiver reset line
`timescale 1ns/10ps
module host_board_model (
    // Control from the bench
    input wire logic hold_reset_in,
    input wire logic [5:0] jumpers_in,
    // Pins towards the transceiver
    output logic rstn_out,
    output strap_cfg_pkg::strap_pins_t straps_out
);
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Reset is released only when the bench lets go of it
    assign rstn_out = ~hold_reset_in;
    // Jumpers always present a firm level, so no strap floats
    assign straps_out = strap_cfg_pkg::strap_pins_t'(jumpers_in);
endmodule : host_board_model

// ### dv/plc_transceiver_strap_config_tb_top.sv
// Bench for the strap capture and configuration loader
`timescale 1ns/10ps
module plc_transceiver_strap_config_tb_top;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk = 1'h0; // 200 MHz
    logic hold_rst = 1'h1; // Reset held from time zero
    logic [5:0] jumpers = 6'h33; // Unjumpered board levels
    logic dbg_valid = 1'h0; // Debug message strobe
    logic rstn;
    strap_cfg_pkg::strap_pins_t straps;
    strap_cfg_pkg::dev_cfg_t cfg;
    logic cfg_valid;
    logic wait_host;
    logic spi_en;
    logic mii_en;
    logic dbg_emit;
    logic [5:0] j;
    logic [5:0] pats [5] = '{6'h33, 6'h00, 6'h3F, 6'h15, 6'h2A};
    int err_total = 0;
    int tests_run = 0;

    // ------------------------------------------------------------------
    // Clock, far side and design
    // ------------------------------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end

    host_board_model i_board (
        .hold_reset_in(hold_rst),
        .jumpers_in(jumpers),
        .rstn_out(rstn),
        .straps_out(straps)
    );

    plc_transceiver_strap_config i_dut (
        .clk_in(clk),
        .rstn_in(rstn),
        .straps_in(straps),
        .dbg_valid_in(dbg_valid),
        .cfg_out(cfg),
        .cfg_valid_out(cfg_valid),
        .boot_wait_host_out(wait_host),
        .spi_port_en_out(spi_en),
        .mii_port_en_out(mii_en),
        .dbg_emit_out(dbg_emit)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Compare one value and count it
    task check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : check

    // Reset with the given jumpers; debug strobes stay high meanwhile
    task boot(input logic [5:0] jv);
        int n;
        @(negedge clk);
        jumpers = jv;
        hold_rst = 1'h1;
        dbg_valid = 1'h1;
        repeat (3) @(negedge clk);
        check({7'h00, cfg_valid}, 8'h00);
        // In reset: ports closed, host wait low, unjumpered defaults shown
        check({5'h00, wait_host, spi_en, mii_en}, 8'h00);
        check({2'h0, cfg}, 8'h03);
        hold_rst = 1'h0;
        n = 0;
        // Bounded wait; no debug may leak out before capture
        while (cfg_valid !== 1'h1 && n < 30) begin
            check({7'h00, dbg_emit}, 8'h00);
            @(negedge clk);
            n++;
        end
        check({7'h00, cfg_valid}, 8'h01);
        dbg_valid = 1'h0;
        @(negedge clk);
    endtask : boot

    // Verdict and end of run
    task conclude;
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // Tests: defaults first, then all-low, all-high and alternating
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 5; i++) begin
            j = pats[i];
            boot(j);
            check({2'h0, cfg},
                {2'h0, ~j[5], ~j[4], j[3], j[2:0]});
            check({7'h00, wait_host}, {7'h00, j[4]});
            check({6'h00, spi_en, mii_en}, 8'h03);
            // One strobe yields one emitted cycle only when enabled
            dbg_valid = 1'h1;
            @(negedge clk);
            dbg_valid = 1'h0;
            check({7'h00, dbg_emit}, {7'h00, ~j[5]});
            @(negedge clk);
            check({7'h00, dbg_emit}, 8'h00);
            // Moving the jumpers in operation must change nothing
            jumpers = ~j;
            repeat (8) @(negedge clk);
            check({2'h0, cfg},
                {2'h0, ~j[5], ~j[4], j[3], j[2:0]});
        end
        conclude();
    end

    // Watchdog: the whole run needs well under 20 us
    initial begin
        #20000;
        err_total++;
        conclude();
    end
endmodule : plc_transceiver_strap_config_tb_top

// ### hdl/plc_transceiver_strap_config.sv
// Strap capture and configuration loader for the line transceiver
//
// Overview of operation
// - Capture six straps at each reset, configure
// - Debug strap 1 disables, 0 enables debug
// - Boot strap 0 flash, 1 wait host
// - SPI strap 1 rising mode1, 0 falling mode3
// - MII address bit 2 from first strap
// - MII address bit 1 from second strap
// - MII address bit 0 from third strap
// - Debug output only after reset release, enabled
// - SPI and MII ports usable together
`timescale 1ns/10ps
module plc_transceiver_strap_config #(
    parameter int SETTLE = strap_cfg_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Strap pins
    input wire strap_cfg_pkg::strap_pins_t straps_in,
    // Debug message source from the core
    input wire logic dbg_valid_in,
    // Decoded configuration
    output strap_cfg_pkg::dev_cfg_t cfg_out,
    output logic cfg_valid_out,
    output logic boot_wait_host_out,
    output logic spi_port_en_out,
    output logic mii_port_en_out,
    output logic dbg_emit_out
);

    // ------------------------------------------------------------------
    // Reset release through two flops
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic rstn; // Synchronised reset used everywhere below

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_r <= 1'h0;
            rst_sync_r <= 1'h0;
        end else begin
            rst_meta_r <= 1'h1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rstn = rst_sync_r;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    strap_cfg_pkg::strap_pins_t straps_s; // Synchronised strap levels

    strap_sync #(
        .W($bits(strap_cfg_pkg::strap_pins_t))
    ) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn),
        .d_in(straps_in),
        .q_out(straps_s)
    );

    // ------------------------------------------------------------------
    // Loader state machine
    // ------------------------------------------------------------------
    // Settle window lets the synchroniser fill with real pin levels,
    // so the capture never sees the flops' reset zeros.
    strap_cfg_pkg::load_state_t state_r;
    strap_cfg_pkg::load_state_t state_nxt;
    logic [7:0] cnt_r; // Settle counter
    logic [7:0] cnt_nxt;
    wire logic settle_done = (cnt_r == 8'(SETTLE - 1));
    wire logic capture = (state_r == strap_cfg_pkg::ST_SETTLE) && settle_done;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            strap_cfg_pkg::ST_RESET: begin
                state_nxt = strap_cfg_pkg::ST_SETTLE;
                cnt_nxt = 8'h00;
            end
            strap_cfg_pkg::ST_SETTLE: begin
                cnt_nxt = cnt_r + 8'h01;
                if (settle_done) begin
                    state_nxt = strap_cfg_pkg::ST_RUN;
                end
            end
            // Run is terminal: only a reset leaves it
            strap_cfg_pkg::ST_RUN: begin
                state_nxt = strap_cfg_pkg::ST_RUN;
            end
            default: begin
                state_nxt = strap_cfg_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            state_r <= strap_cfg_pkg::ST_RESET;
            cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Decode of live synced straps
    // ------------------------------------------------------------------
    strap_cfg_pkg::dev_cfg_t dec; // Configuration from live synced pins
    assign dec.debug_en = ~straps_s.debug_port_off_strap;
    assign dec.boot_from_flash =
        (straps_s.boot_source_strap == strap_cfg_pkg::BOOT_FROM_FLASH);
    assign dec.spi_sample_rising =
        (straps_s.spi_edge_strap == strap_cfg_pkg::SPI_RISING_MODE1);
    assign dec.mii_addr[strap_cfg_pkg::MII_ADDR_BIT2_POS] =
        straps_s.mii_addr_bit2_strap;
    assign dec.mii_addr[strap_cfg_pkg::MII_ADDR_BIT1_POS] =
        straps_s.mii_addr_bit1_strap;
    assign dec.mii_addr[strap_cfg_pkg::MII_ADDR_BIT0_POS] =
        straps_s.mii_addr_bit0_strap;

    // Reset value mirrors the unjumpered defaults
    localparam strap_cfg_pkg::dev_cfg_t CFG_RESET = '{
        debug_en: ~strap_cfg_pkg::DEBUG_OFF_DEFAULT,
        boot_from_flash: ~strap_cfg_pkg::BOOT_SRC_DEFAULT,
        spi_sample_rising: strap_cfg_pkg::SPI_EDGE_DEFAULT,
        mii_addr: strap_cfg_pkg::MII_ADDR_DEFAULT
    };

    // ------------------------------------------------------------------
    // Capture register and port outputs
    // ------------------------------------------------------------------
    // Capture happens once per reset; pin moves afterwards are ignored.
    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            cfg_out <= CFG_RESET;
            cfg_valid_out <= 1'h0;
            boot_wait_host_out <= 1'h0;
            spi_port_en_out <= 1'h0;
            mii_port_en_out <= 1'h0;
        end else if (capture) begin
            cfg_out <= dec;
            cfg_valid_out <= 1'h1;
            boot_wait_host_out <= ~dec.boot_from_flash;
            // Both host ports open together, independent of each other
            spi_port_en_out <= 1'h1;
            mii_port_en_out <= 1'h1;
        end
    end

    // ------------------------------------------------------------------
    // Debug message gate
    // ------------------------------------------------------------------
    // Only emitted after reset release and capture, and only if enabled.
    always_ff @(posedge clk_in or negedge rstn) begin
        if (!rstn) begin
            dbg_emit_out <= 1'h0;
        end else begin
            dbg_emit_out <= dbg_valid_in && cfg_valid_out
                && cfg_out.debug_en;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Field checks compare against the synced pins one edge back, so a
    // swapped or inverted debug, SPI or MII address field shows even when the bundle check agrees.
    chk_cfg_held: assert property (
        @(posedge clk_in) disable iff (!rstn)
        cfg_valid_out && $past(cfg_valid_out) |-> $stable(cfg_out))
        else $error("Captured configuration changed after load");
    chk_valid_sticky: assert property (
        @(posedge clk_in) disable iff (!rstn)
        cfg_valid_out |=> cfg_valid_out)
        else $error("Configuration valid dropped without reset");
    chk_dbg_gate: assert property (
        @(posedge clk_in) disable iff (!rstn)
        dbg_emit_out |-> $past(cfg_valid_out) && $past(cfg_out.debug_en))
        else $error("Debug emitted while disabled or before load");
    chk_dbg_pass: assert property (
        @(posedge clk_in) disable iff (!rstn)
        cfg_valid_out && cfg_out.debug_en && dbg_valid_in |=> dbg_emit_out)
        else $error("Enabled debug message was blocked");
    chk_load_time: assert property (
        @(posedge clk_in) disable iff (!rstn)
        $rose(state_r == strap_cfg_pkg::ST_SETTLE) |-> ##[1:300] cfg_valid_out)
        else $error("Configuration not loaded in time");
    chk_capture_val: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=> cfg_out == $past(dec))
        else $error("Captured configuration differs from straps");
    chk_boot_host: assert property (
        @(posedge clk_in) disable iff (!rstn)
        cfg_valid_out |-> boot_wait_host_out == !cfg_out.boot_from_flash)
        else $error("Boot wait does not match boot source");
    chk_addr_bits: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=> cfg_out.mii_addr == {$past(straps_s.mii_addr_bit2_strap),
        $past(straps_s.mii_addr_bit1_strap),
        $past(straps_s.mii_addr_bit0_strap)})
        else $error("MII address bits mismatch straps");
    chk_ports_on: assert property (
        @(posedge clk_in) disable iff (!rstn)
        cfg_valid_out |-> spi_port_en_out && mii_port_en_out)
        else $error("Host ports not both enabled");
    chk_spi_edge: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=>
            cfg_out.spi_sample_rising == $past(straps_s.spi_edge_strap))
        else $error("SPI sampling edge differs from strap");
    chk_dbg_polarity: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=>
            cfg_out.debug_en == !$past(straps_s.debug_port_off_strap))
        else $error("Debug enable polarity wrong");
    chk_addr_bit1: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=>
            cfg_out.mii_addr[1] == $past(straps_s.mii_addr_bit1_strap))
        else $error("MII address bit 1 differs from strap");
    chk_addr_bit0: assert property (
        @(posedge clk_in) disable iff (!rstn)
        capture |=>
            cfg_out.mii_addr[0] == $past(straps_s.mii_addr_bit0_strap))
        else $error("MII address bit 0 differs from strap");

    cov_load: cover property (@(posedge clk_in) disable iff (!rstn)
        $rose(cfg_valid_out));
    cov_dbg: cover property (@(posedge clk_in) disable iff (!rstn)
        dbg_emit_out);
    cov_flash: cover property (@(posedge clk_in) disable iff (!rstn)
        cfg_valid_out && cfg_out.boot_from_flash);
    cov_pin_move: cover property (@(posedge clk_in) disable iff (!rstn)
        cfg_valid_out && !$stable(straps_s));

endmodule : plc_transceiver_strap_config

// ### hdl/strap_sync.sv
// Two-flop synchroniser for a bundle of slow pin levels
`timescale 1ns/10ps
module strap_sync #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_r; // First stage, read only by the second
    logic [W-1:0] sync_r; // Second stage

    // ------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule : strap_sync

// ### inc/strap_cfg_pkg.sv
// Package: constants and carrier types for the strap configuration loader
package strap_cfg_pkg;

    // ------------------------------------------------------------------
    // Strap defaults (levels that the unjumpered board presents)
    // ------------------------------------------------------------------
    localparam logic DEBUG_OFF_DEFAULT = 1'h1;
    localparam logic BOOT_SRC_DEFAULT = 1'h1;
    localparam logic SPI_EDGE_DEFAULT = 1'h0;
    localparam logic [2:0] MII_ADDR_DEFAULT = 3'h3;

    // ------------------------------------------------------------------
    // Field positions of the MII address
    // ------------------------------------------------------------------
    localparam int MII_ADDR_BIT2_POS = 2;
    localparam int MII_ADDR_BIT1_POS = 1;
    localparam int MII_ADDR_BIT0_POS = 0;
    localparam int MII_ADDR_W = 3;

    // ------------------------------------------------------------------
    // Strap encodings
    // ------------------------------------------------------------------
    localparam logic BOOT_FROM_FLASH = 1'h0;
    localparam logic SPI_RISING_MODE1 = 1'h1;

    // ------------------------------------------------------------------
    // Timing: strap settle window after reset release, in cycles
    // ------------------------------------------------------------------
    localparam int SETTLE_CYCLES = 4;

    // Raw strap pin levels as one bundle
    typedef struct packed {
        logic debug_port_off_strap;
        logic boot_source_strap;
        logic spi_edge_strap;
        logic mii_addr_bit2_strap;
        logic mii_addr_bit1_strap;
        logic mii_addr_bit0_strap;
    } strap_pins_t;

    // Decoded configuration that the device runs with
    typedef struct packed {
        logic debug_en;
        logic boot_from_flash;
        logic spi_sample_rising;
        logic [2:0] mii_addr;
    } dev_cfg_t;

    // Loader state
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_SETTLE = 2'h1,
        ST_RUN = 2'h3
    } load_state_t;

endpackage : strap_cfg_pkg
